// >>> core/stats_pkg.sv
package stats_pkg;

  // Host data bus and direct dword addressing
  localparam int HOST_DATA_W = 32;
  localparam int HOST_ADR_W = 2;
  localparam logic [1:0] HOST_ADR_INDEX = 2'h0;
  localparam logic [1:0] HOST_ADR_DATA = 2'h1;

  // Indirect index space
  localparam int INDEX_W = 9;
  localparam logic [8:0] INDEX_RESET = 9'h000;
  localparam logic [8:0] IDX_LUMA_MIN = 9'h0AD;
  localparam logic [8:0] IDX_LUMA_MAX = 9'h0AE;
  localparam logic [8:0] IDX_BLUE_MIN = 9'h0AF;
  localparam logic [8:0] IDX_BLUE_MAX = 9'h0B0;
  localparam logic [8:0] IDX_RED_MIN = 9'h0B1;
  localparam logic [8:0] IDX_RED_MAX = 9'h0B2;
  localparam logic [8:0] IDX_TABLE_FIRST = 9'h100;
  localparam logic [8:0] IDX_TABLE_LAST = 9'h153;

  // Statistic and table value layout
  localparam int VALUE_W = 16;
  localparam int TABLE_DEPTH = 84;
  localparam int TABLE_ADDR_W = 7;
  localparam int PAIR_W = 6;
  localparam logic [15:0] VALUE_ZERO = 16'h0000;

  // Fixed-point formats: step is 8.8, inverse step is 6.10
  localparam int STEP_FRAC_BITS = 8;
  localparam int STEP_INV_FRAC_BITS = 10;

  // Component select codes on the pixel input
  typedef enum logic [1:0] {
    COMP_LUMA = 2'h0,
    COMP_BLUE = 2'h1,
    COMP_RED = 2'h2
  } component_t;
  localparam int NUM_COMP = 3;

endpackage

// >>> core/quant_table_if.sv
`timescale 1ns/100ps
interface quant_table_if;
  import stats_pkg::*;

  // Host side write and read
  logic wr_en;
  logic [TABLE_ADDR_W-1:0] wr_addr;
  logic [VALUE_W-1:0] wr_data;
  logic [TABLE_ADDR_W-1:0] host_addr;
  logic [VALUE_W-1:0] host_rdata;
  // Quantizer pair read
  logic pair_rd;
  logic [PAIR_W-1:0] pair_idx;
  logic pair_valid;
  logic [VALUE_W-1:0] step;
  logic [VALUE_W-1:0] step_inverse;

  modport ctrl (
    output wr_en, wr_addr, wr_data, host_addr, pair_rd, pair_idx,
    input host_rdata, pair_valid, step, step_inverse
  );
  modport mem (
    input wr_en, wr_addr, wr_data, host_addr, pair_rd, pair_idx,
    output host_rdata, pair_valid, step, step_inverse
  );
endinterface

// >>> core/quant_table_mem.sv
`timescale 1ns/100ps
module quant_table_mem
  import stats_pkg::*;
#(
  parameter int DEPTH = TABLE_DEPTH
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Table port
  quant_table_if.mem tbl
);

  // Contents are left uninitialised; software loads every entry before use
  logic [VALUE_W-1:0] entry [DEPTH];

  // Host write port
  always_ff @(posedge clk)
  begin
    if (tbl.wr_en)
      entry[tbl.wr_addr] <= tbl.wr_data;
  end

  // Host read port, registered, follows the index every cycle
  always_ff @(posedge clk)
  begin
    tbl.host_rdata <= entry[tbl.host_addr];
  end

  // Pair read: even entry is the inverse step, odd entry the step
  always_ff @(posedge clk)
  begin
    if (tbl.pair_rd)
    begin
      tbl.step_inverse <= entry[{tbl.pair_idx, 1'b0}];
      tbl.step <= entry[{tbl.pair_idx, 1'b1}];
    end
  end

  // Pair valid is control state and so is reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tbl.pair_valid <= 1'b0;
    else
      tbl.pair_valid <= tbl.pair_rd;
  end

endmodule // quant_table_mem

// >>> core/pixel_stats_and_quant_table.sv
`timescale 1ns/100ps
// Operation
// - Index 0x0AD reads the smallest luma sample seen, read-only, 16 bits.
// - Index 0x0AE reads the largest luma sample seen, read-only, 16 bits.
// - Index 0x0AF reads the smallest blue chroma sample seen, read-only.
// - Index 0x0B0 reads the largest blue chroma sample seen, read-only.
// - Index 0x0B1 reads the smallest red chroma sample seen, read-only.
// - Index 0x0B2 reads the largest red chroma sample seen, read-only.
// - Statistic reads return zero in bits 31 to 16.
// - Statistic values are not reset; undefined until gathered.
// - Indices 0x100 to 0x153 form a readable, writable table of 84 entries.
// - Even table indices hold inverse steps, odd indices hold steps.
// - Step entries are unsigned 8.8 fixed point.
// - Inverse step entries are unsigned 6.10 fixed point.
// - Table entries are not reset; undefined until written.
// - Host reaches the indexed space through two dword-addressed registers, index at dword 0 and data at dword 1.
module pixel_stats_and_quant_table
  import stats_pkg::*;
#(
  parameter int PIX_W = 8,
  parameter int DEPTH = TABLE_DEPTH
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Host interface
  input wire logic host_cs_n_i,
  input wire logic host_wr_n_i,
  input wire logic host_rd_n_i,
  input wire logic [HOST_ADR_W-1:0] host_adr_i,
  input wire logic [HOST_DATA_W-1:0] host_data_i,
  output logic [HOST_DATA_W-1:0] host_data_o,
  output logic host_data_oe_o,
  // Video sample input
  input wire logic enc_mode_i,
  input wire logic field_start_i,
  input wire logic pix_valid_i,
  input wire logic [1:0] pix_comp_i,
  input wire logic [PIX_W-1:0] pix_data_i,
  // Quantizer pair read
  input wire logic quant_rd_i,
  input wire logic [PAIR_W-1:0] quant_pair_i,
  output logic quant_valid_o,
  output logic [VALUE_W-1:0] quant_step_o,
  output logic [VALUE_W-1:0] quant_step_inverse_o
);

  // Reset release through two flops; assertion stays asynchronous
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Host strobe decode
  logic wr_level;
  logic rd_level;
  logic wr_seen;
  logic wr_take;

  assign wr_level = !host_cs_n_i && !host_wr_n_i;
  assign rd_level = !host_cs_n_i && !host_rd_n_i;
  // A held write strobe must commit once, so only its first cycle counts
  assign wr_take = wr_level && !wr_seen;

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      wr_seen <= 1'b0;
    else
      wr_seen <= wr_level;
  end

  // Indirect index register behind dword 0
  logic [INDEX_W-1:0] index;
  logic [INDEX_W-1:0] next_index;

  always_comb
  begin
    next_index = index;
    if (wr_take && host_adr_i == HOST_ADR_INDEX)
      next_index = host_data_i[INDEX_W-1:0];
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      index <= INDEX_RESET;
    else
      index <= next_index;
  end

  // Index classification
  logic in_table;
  logic [TABLE_ADDR_W-1:0] table_addr;
  logic [INDEX_W-1:0] table_offset;

  // Table span decode; everything else in the data dword is a statistic or unmapped
  assign in_table = (index >= IDX_TABLE_FIRST) && (index <= IDX_TABLE_LAST);
  assign table_offset = index - IDX_TABLE_FIRST;
  assign table_addr = table_offset[TABLE_ADDR_W-1:0];

  // Carrier to the table memory
  quant_table_if tbl ();

  // Only table indices reach the memory; statistic writes fall away here
  assign tbl.wr_en = wr_take && host_adr_i == HOST_ADR_DATA && in_table;
  assign tbl.wr_addr = table_addr;
  assign tbl.wr_data = host_data_i[VALUE_W-1:0];
  assign tbl.host_addr = table_addr;

  // Quantizer fetches one step pair; values are stored raw as written
  assign tbl.pair_rd = quant_rd_i && enc_mode_i;
  assign tbl.pair_idx = quant_pair_i;

  quant_table_mem #(
    .DEPTH(DEPTH)
  ) u_table (
    .clk(core_clk_i),
    .rst_n(rst_n),
    .tbl(tbl.mem)
  );

  // Step is 8.8 and inverse is 6.10; the quantizer applies the binary points
  assign quant_valid_o = tbl.pair_valid;
  assign quant_step_o = tbl.step;
  assign quant_step_inverse_o = tbl.step_inverse;

  // Pixel widening to the statistic width
  logic [VALUE_W-1:0] pix_wide;

  assign pix_wide = VALUE_W'(pix_data_i);

  // Per-component minimum and maximum trackers
  logic [VALUE_W-1:0] stat_min [NUM_COMP];
  logic [VALUE_W-1:0] stat_max [NUM_COMP];
  logic [NUM_COMP-1:0] seen;

  genvar c;
  generate
    for (c = 0; c < NUM_COMP; c++)
    begin : g_track
      logic hit;
      logic fresh;

      // Only valid samples during encode are tracked
      assign hit = pix_valid_i && enc_mode_i && pix_comp_i == 2'(c);
      // A sample in the field-start cycle opens the new field
      assign fresh = field_start_i || !seen[c];

      // Seen flag is control state, cleared by reset and at a field start that brings no sample for this component
      always_ff @(posedge core_clk_i or negedge rst_n)
      begin
        if (!rst_n)
          seen[c] <= 1'b0;
        else if (hit)
          seen[c] <= 1'b1;
        else if (field_start_i)
          seen[c] <= 1'b0;
      end

      // Values carry no reset and read undefined before the first sample
      always_ff @(posedge core_clk_i)
      begin
        if (hit && (fresh || pix_wide < stat_min[c]))
          stat_min[c] <= pix_wide;
      end

      always_ff @(posedge core_clk_i)
      begin
        if (hit && (fresh || pix_wide > stat_max[c]))
          stat_max[c] <= pix_wide;
      end
    end
  endgenerate

  // Statistic read mux
  logic [VALUE_W-1:0] stat_value;
  logic stat_hit;

  always_comb
  begin
    stat_value = VALUE_ZERO;
    stat_hit = 1'b1;
    case (index)
      IDX_LUMA_MIN: stat_value = stat_min[COMP_LUMA];
      IDX_LUMA_MAX: stat_value = stat_max[COMP_LUMA];
      IDX_BLUE_MIN: stat_value = stat_min[COMP_BLUE];
      IDX_BLUE_MAX: stat_value = stat_max[COMP_BLUE];
      IDX_RED_MIN: stat_value = stat_min[COMP_RED];
      IDX_RED_MAX: stat_value = stat_max[COMP_RED];
      default: stat_hit = 1'b0;
    endcase
  end

  // Host read word; upper half always zero for indexed values
  logic [HOST_DATA_W-1:0] read_word;

  always_comb
  begin
    read_word = '0;
    case (host_adr_i)
      HOST_ADR_INDEX:
        read_word = HOST_DATA_W'(index);
      HOST_ADR_DATA:
      begin
        if (in_table)
          read_word = HOST_DATA_W'(tbl.host_rdata);
        else if (stat_hit)
          read_word = HOST_DATA_W'(stat_value);
      end
      default:
        read_word = '0;
    endcase
  end

  // Read data sampled every read cycle; table data lags the index by one cycle
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      host_data_o <= '0;
    else if (rd_level)
      host_data_o <= read_word;
  end

  // Drive the data pins in the cycle after each host read cycle
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      host_data_oe_o <= 1'b0;
    else
      host_data_oe_o <= rd_level;
  end

endmodule // pixel_stats_and_quant_table

// >>> testbench/pixel_stats_sva.sv
`timescale 1ns/100ps
// Port checks on the host read path and the quantizer pair port
module pixel_stats_sva
  import stats_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Host and quantizer signals
  input wire logic host_cs_n_i,
  input wire logic host_rd_n_i,
  input wire logic [HOST_DATA_W-1:0] host_data_o,
  input wire logic host_data_oe_o,
  input wire logic enc_mode_i,
  input wire logic quant_rd_i,
  input wire logic quant_valid_o,
  input wire logic [VALUE_W-1:0] quant_step_o,
  input wire logic [VALUE_W-1:0] quant_step_inverse_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  a_oe_rise: assert property (!host_cs_n_i && !host_rd_n_i |=> host_data_oe_o)
    else $error("enable not raised after read");
  a_oe_fall: assert property (host_cs_n_i || host_rd_n_i |=> !host_data_oe_o)
    else $error("enable left high without read");
  a_upper_zero: assert property (host_data_oe_o |-> host_data_o[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_data_holds: assert property (!host_data_oe_o |-> $stable(host_data_o))
    else $error("read data moved outside a read");
  a_pair_answer: assert property (quant_rd_i && enc_mode_i |=> quant_valid_o)
    else $error("pair fetch not answered");
  a_pair_refused: assert property (!(quant_rd_i && enc_mode_i) |=> !quant_valid_o)
    else $error("pair valid without fetch");
  a_step_holds: assert property (quant_valid_o ##1 !quant_valid_o |-> $stable(quant_step_o))
    else $error("step moved between fetches");
  a_inverse_holds: assert property (
    quant_valid_o ##1 !quant_valid_o |-> $stable(quant_step_inverse_o))
    else $error("inverse step moved between fetches");
endmodule // pixel_stats_sva

bind pixel_stats_and_quant_table pixel_stats_sva u_pixel_stats_sva (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .host_cs_n_i(host_cs_n_i),
  .host_rd_n_i(host_rd_n_i), .host_data_o(host_data_o), .host_data_oe_o(host_data_oe_o),
  .enc_mode_i(enc_mode_i), .quant_rd_i(quant_rd_i), .quant_valid_o(quant_valid_o),
  .quant_step_o(quant_step_o), .quant_step_inverse_o(quant_step_inverse_o));

// >>> testbench/host_model.sv
`timescale 1ns/100ps
// Host processor: one access at a time, pins change on falling edges
module host_model
  import stats_pkg::*;
(
  // Bus pins
  input wire logic clk_i,
  input wire logic [HOST_DATA_W-1:0] rdata_i,
  output logic cs_n_o,
  output logic wr_n_o,
  output logic rd_n_o,
  output logic [HOST_ADR_W-1:0] adr_o,
  output logic [HOST_DATA_W-1:0] wdata_o
);
  initial {cs_n_o, wr_n_o, rd_n_o, adr_o, wdata_o} = {3'h7, 2'h0, 32'h00000000};
  // Strobe high a cycle between writes, so each is taken once
  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(negedge clk_i);
    {cs_n_o, wr_n_o, adr_o, wdata_o} = {2'h0, a, d};
    @(negedge clk_i);
    {cs_n_o, wr_n_o} = 2'h3;
    wdata_o = ~d; // Released bus shows no stale value
  endtask
  // Read held three cycles so a fresh index reaches table data
  task automatic rd(input logic [1:0] a, output logic [31:0] d);
    @(negedge clk_i);
    {cs_n_o, rd_n_o, adr_o} = {2'h0, a};
    repeat (3) @(negedge clk_i);
    d = rdata_i;
    {cs_n_o, rd_n_o} = 2'h3;
  endtask
  // Indexed access: index register first, then data register
  task automatic put(input logic [8:0] i, input logic [15:0] v);
    wr(HOST_ADR_INDEX, {23'h000000, i});
    wr(HOST_ADR_DATA, {16'h0000, v});
  endtask
  task automatic get(input logic [8:0] i, output logic [31:0] d);
    wr(HOST_ADR_INDEX, {23'h000000, i});
    rd(HOST_ADR_DATA, d);
  endtask
endmodule // host_model

// >>> testbench/test_pixel_stats_and_quant_table.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end
module test_pixel_stats_and_quant_table;
  import stats_pkg::*;
  logic core_clk_i = 0;
  logic arst_n_i = 0;
  logic cs_n, wr_n, rd_n, enc = 0, fs = 0, pv = 0, qrd = 0, qv;
  logic [1:0] adr, comp = 0;
  logic [31:0] wd, rdat, d;
  logic [7:0] pix = 0;
  logic [5:0] pair = 0;
  logic [15:0] step, inv;
  logic [15:0] ex [6] = '{16'h0010, 16'h00F0, 16'h007F, 16'h0080, 16'h0005, 16'h00FA};
  logic [9:0] sq [8] = '{10'h040, 10'h010, 10'h0F0, 10'h180, 10'h17F, 10'h205, 10'h2FA, 10'h300};
  logic [6:0] pl [3] = '{7'h40, 7'h69, 7'h14};
  int fail_count = 0;
  int checked = 0;

  pixel_stats_and_quant_table u_pixel_stats_and_quant_table (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .host_cs_n_i(cs_n), .host_wr_n_i(wr_n),
    .host_rd_n_i(rd_n), .host_adr_i(adr), .host_data_i(wd), .host_data_o(rdat),
    .host_data_oe_o(), .enc_mode_i(enc), .field_start_i(fs), .pix_valid_i(pv),
    .pix_comp_i(comp), .pix_data_i(pix), .quant_rd_i(qrd), .quant_pair_i(pair),
    .quant_valid_o(qv), .quant_step_o(step), .quant_step_inverse_o(inv));
  host_model u_host_model (.clk_i(core_clk_i), .rdata_i(rdat), .cs_n_o(cs_n),
    .wr_n_o(wr_n), .rd_n_o(rd_n), .adr_o(adr), .wdata_o(wd));

  // Distinct value per table entry
  function automatic logic [15:0] tv(input int i);
    return 16'(i * 16'h0203 + 16'h1357);
  endfunction
  // One video sample, then an idle cycle
  task automatic smp(input logic [1:0] c, input logic [7:0] v, input logic f);
    @(negedge core_clk_i);
    {pv, comp, pix, fs} = {1'b1, c, v, f};
    @(negedge core_clk_i);
    {pv, fs} = 2'h0;
  endtask
  // Pair fetch; en low means the fetch must be refused
  task automatic fetch(input logic [5:0] p, input logic en);
    @(negedge core_clk_i);
    {qrd, pair, enc} = {1'b1, p, en};
    @(negedge core_clk_i);
    qrd = 0;
    `CHK("valid", en, qv)
    if (en)
    begin
      `CHK("step", tv(2 * int'(p) + 1), step)
      `CHK("inverse", tv(2 * int'(p)), inv)
    end
  endtask
  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial forever #5 core_clk_i = ~core_clk_i;
  // Run needs about a thousand cycles; 400 us leaves ample margin
  initial
  begin
    #400us;
    fail_count++;
    $display("[ERR] watchdog exp done got hang");
    finish_test();
  end
  // Main sequence
  initial
  begin
    repeat (10) @(negedge core_clk_i);
    arst_n_i = 1;
    repeat (3) @(negedge core_clk_i);
    enc = 1;
    foreach (sq[i]) smp(sq[i][9:8], sq[i][7:0], i == 0);
    enc = 0;
    smp(2'h0, 8'h01, 1'b0); // Gated out of encode
    for (int i = 0; i < 6; i++)
    begin
      u_host_model.get(IDX_LUMA_MIN + 9'(i), d);
      `CHK("stat", {16'h0000, ex[i]}, d)
    end
    u_host_model.put(IDX_LUMA_MIN, 16'hFFFF);
    u_host_model.get(IDX_LUMA_MIN, d);
    `CHK("ro stat", 32'h00000010, d)
    enc = 1;
    smp(2'h0, 8'h99, 1'b1);
    for (int i = 0; i < 2; i++)
    begin
      u_host_model.get(IDX_LUMA_MIN + 9'(i), d);
      `CHK("new field", 32'h00000099, d)
    end
    $display("stats test done");
    for (int i = 0; i < TABLE_DEPTH; i++)
      u_host_model.put(IDX_TABLE_FIRST + 9'(i), tv(i));
    for (int i = 0; i < TABLE_DEPTH; i++)
    begin
      u_host_model.get(IDX_TABLE_FIRST + 9'(i), d);
      `CHK("table", {16'h0000, tv(i)}, d)
    end
    u_host_model.get(IDX_TABLE_LAST + 9'h001, d);
    `CHK("unmapped", 32'h00000000, d)
    u_host_model.rd(HOST_ADR_INDEX, d);
    `CHK("index", 32'h00000154, d)
    u_host_model.rd(2'h2, d);
    `CHK("dword 2", 32'h00000000, d)
    $display("table test done");
    foreach (pl[i]) fetch(pl[i][5:0], pl[i][6]);
    $display("quantizer test done");
    finish_test();
  end
endmodule // test_pixel_stats_and_quant_table
